// *** hdl/watchdog_map.vh ***
// Constants for the one-time enabled hardware watchdog
`ifndef WATCHDOG_MAP_VH
`define WATCHDOG_MAP_VH
`define SERVICE_KEY_ADDR   8'hA6
`define KEY_FIRST          8'h1E
`define KEY_SECOND         8'hE1
`define COUNT_WIDTH        14
`define COUNT_ZERO         14'h0000
`define COUNT_ONE          14'h0001
`define COUNT_LIMIT        14'h3FFF
`define OSC_PER_MACHINE    4'hC
`define TICK_CNT_ZERO      4'h0
`define TICK_CNT_ONE       4'h1
`define PULSE_OSC_PERIODS  7'h62
`define PULSE_CNT_ZERO     7'h00
`define PULSE_CNT_ONE      7'h01
`endif

// *** hdl/machine_tick.v ***
// Divider producing one machine-cycle enable per twelve oscillator periods
`timescale 1ns/1ps
`include "watchdog_map.vh"
module machine_tick #(
   // Oscillator periods per machine cycle
   parameter [3:0] DIVIDE = `OSC_PER_MACHINE
) (
   // Clock and reset
   input  wire       core_clk,
   input  wire       reset_n,
   // Oscillator running qualifier
   input  wire       osc_running,
   // Machine-cycle strobe
   output reg        tick
);
   reg  [3:0] osc_count;

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_count <= `TICK_CNT_ZERO;
         tick      <= 1'b0;
      end else if (osc_running) begin
         if (osc_count == DIVIDE - `TICK_CNT_ONE) begin
            osc_count <= `TICK_CNT_ZERO;
            tick      <= 1'b1;
         end else begin
            osc_count <= osc_count + `TICK_CNT_ONE;
            tick      <= 1'b0;
         end
      end else begin
         tick <= 1'b0;
      end
   end
endmodule

// *** hdl/hardware_watchdog.v ***
// One-time enabled hardware watchdog with reset-out pulse
`timescale 1ns/1ps
`include "watchdog_map.vh"
module hardware_watchdog #(
   // Oscillator periods per machine cycle; a bench may shorten it
   parameter [3:0] TICK_DIV = `OSC_PER_MACHINE
) (
   // Clock (oscillator) and reset
   input  wire       core_clk,
   input  wire       reset_n,
   // Oscillator running qualifier
   input  wire       osc_running,
   // Special function register write port
   input  wire       sfr_wr,
   input  wire [7:0] sfr_addr,
   input  wire [7:0] sfr_wdata,
   // Reset pin drive
   output reg        rst_pin_out,
   output reg        rst_pin_oe,
   // Internal device reset request
   output reg        device_reset
);
   // Watchdog states
   localparam [1:0] DISARMED  = 2'h0;
   localparam [1:0] ARMED     = 2'h1;
   localparam [1:0] RESET_OUT = 2'h2;

   // State and counters
   reg  [1:0]                 state;
   reg  [1:0]                 next_state;
   reg  [`COUNT_WIDTH-1:0]    count;
   reg  [`COUNT_WIDTH-1:0]    next_count;
   reg  [6:0]                 pulse_count;
   reg  [6:0]                 next_pulse_count;
   // Key sequence tracking
   reg                        key_seen;
   reg                        next_key_seen;
   // Next values of the outputs
   reg                        next_pin_out;
   reg                        next_pin_oe;
   reg                        next_device_reset;
   // Decoded events
   wire                       tick;
   wire                       key_wr;
   wire                       key_first;
   wire                       key_second;
   wire                       pair_done;
   wire                       is_armed;
   wire                       is_pulse;
   wire                       at_limit;
   wire                       overflow;
   wire                       pulse_done;

   // Machine-cycle strobe, frozen while the oscillator is stopped
   machine_tick #(
      .DIVIDE      (TICK_DIV)
   ) i_machine_tick (
      .core_clk    (core_clk),
      .reset_n     (reset_n),
      .osc_running (osc_running),
      .tick        (tick)
   );

   // Only writes decode; there is no read path at all
   assign key_wr     = sfr_wr && (sfr_addr == `SERVICE_KEY_ADDR);
   assign key_first  = key_wr && (sfr_wdata == `KEY_FIRST);
   assign key_second = key_wr && (sfr_wdata == `KEY_SECOND);
   assign pair_done  = key_seen && key_second;

   // State and limit decode
   assign is_armed   = (state == ARMED);
   assign is_pulse   = (state == RESET_OUT);
   assign at_limit   = (count == `COUNT_LIMIT);
   assign overflow   = is_armed && at_limit;
   assign pulse_done = is_pulse && (pulse_count == `PULSE_OSC_PERIODS);

   // A first key primes; any other byte at the service address drops it
   always @* begin
      next_key_seen = key_seen;
      if (is_pulse || overflow) begin
         next_key_seen = 1'b0;
      end else if (key_wr) begin
         next_key_seen = key_first;
      end
   end

   // Once armed, only the overflow leaves the armed state
   always @* begin
      next_state = state;
      case (state)
         DISARMED: begin
            if (pair_done) begin
               next_state = ARMED;
            end
         end
         ARMED: begin
            if (overflow) begin
               next_state = RESET_OUT;
            end
         end
         RESET_OUT: begin
            if (pulse_done) begin
               next_state = DISARMED;
            end
         end
         default: begin
            next_state = DISARMED;
         end
      endcase
   end

   // Counter runs only while armed; a completed key pair restarts it
   always @* begin
      next_count = count;
      case (state)
         DISARMED: begin
            next_count = `COUNT_ZERO;
         end
         ARMED: begin
            // Overflow wins over a key pair landing in the same cycle
            if (overflow) begin
               next_count = `COUNT_ZERO;
            end else if (pair_done) begin
               next_count = `COUNT_ZERO;
            end else if (tick) begin
               next_count = count + `COUNT_ONE;
            end
         end
         RESET_OUT: begin
            next_count = `COUNT_ZERO;
         end
         default: begin
            next_count = `COUNT_ZERO;
         end
      endcase
   end

   // Pulse length counted in oscillator periods, not machine cycles
   always @* begin
      next_pulse_count = `PULSE_CNT_ZERO;
      if (overflow) begin
         next_pulse_count = `PULSE_CNT_ONE;
      end else if (is_pulse && !pulse_done) begin
         next_pulse_count = pulse_count + `PULSE_CNT_ONE;
      end
   end

   // Pin, enable and internal reset rise and fall together
   always @* begin
      next_pin_out      = (next_state == RESET_OUT);
      next_pin_oe       = (next_state == RESET_OUT);
      next_device_reset = (next_state == RESET_OUT);
   end

   // Watchdog state
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= DISARMED;
      end else begin
         state <= next_state;
      end
   end

   // Timeout counter
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= `COUNT_ZERO;
      end else begin
         count <= next_count;
      end
   end

   // Pulse counter
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pulse_count <= `PULSE_CNT_ZERO;
      end else begin
         pulse_count <= next_pulse_count;
      end
   end

   // Key sequence
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         key_seen <= 1'b0;
      end else begin
         key_seen <= next_key_seen;
      end
   end

   // Reset pin drive, registered so the pin never sees decode glitches
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_pin_out <= 1'b0;
         rst_pin_oe  <= 1'b0;
      end else begin
         rst_pin_out <= next_pin_out;
         rst_pin_oe  <= next_pin_oe;
      end
   end

   // Internal reset request to the rest of the device
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         device_reset <= 1'b0;
      end else begin
         device_reset <= next_device_reset;
      end
   end
endmodule

// *** bench/hardware_watchdog_checker.sv ***
// Reset-pin pulse checks for the watchdog
`timescale 1ns/1ps
module hardware_watchdog_checker #(
   parameter int TICK_DIV = 12
) (
   // Clock and reset
   input wire core_clk,
   input wire reset_n,
   // Oscillator running qualifier
   input wire osc_running,
   // Reset pin and internal reset request
   input wire rst_pin_out,
   input wire rst_pin_oe,
   input wire device_reset
);
   // Fewest running cycles between a service and the first sampled pulse edge
   localparam int MIN_RUN = 16382 * TICK_DIV + 1;
   logic [6:0]  hi;
   logic [17:0] run;
   // High-time of the pulse, and running cycles since reset or the last pulse
   always @(posedge core_clk or negedge reset_n) begin
      hi  <= !reset_n ? 7'h00 : rst_pin_out ? hi + 7'h01 : 7'h00;
      run <= (!reset_n || rst_pin_out) ? 18'h00000 : run + {17'h00000, osc_running};
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_oe_follows: assert property (rst_pin_oe == rst_pin_out) else $error("oe");
   a_reset_pair: assert property (device_reset == rst_pin_out) else $error("rst");
   a_pulse_short: assert property (rst_pin_out |-> hi < 7'h62) else $error("long");
   a_pulse_len: assert property ($fell(rst_pin_out) |-> hi == 7'h62) else $error("len");
   a_pulse_exact: assert property ($rose(rst_pin_out) |-> ##97 rst_pin_out ##1 !rst_pin_out)
      else $error("end");
   a_pulse_holds: assert property ($rose(rst_pin_out) |-> rst_pin_out[*8]) else $error("drop");
   a_no_early: assert property ($rose(rst_pin_out) |-> run > MIN_RUN) else $error("early");
   a_quiet_after: assert property ($fell(rst_pin_out) |-> !rst_pin_out[*8]) else $error("re");
endmodule
bind hardware_watchdog hardware_watchdog_checker #(
   .TICK_DIV     (TICK_DIV)
) i_chk (
   .core_clk     (core_clk),
   .reset_n      (reset_n),
   .osc_running  (osc_running),
   .rst_pin_out  (rst_pin_out),
   .rst_pin_oe   (rst_pin_oe),
   .device_reset (device_reset)
);

// *** bench/cpu_sfr_writer.sv ***
// CPU-side writer for the service register
`timescale 1ns/1ps
module cpu_sfr_writer (
   input  wire       core_clk,
   output reg        sfr_wr = 1'h0,
   output reg  [7:0] sfr_addr = 8'h00,
   output reg  [7:0] sfr_wdata = 8'h00
);
   // Released bus shows inverted values, never the last ones
   task wr(input [7:0] a, input [7:0] d);
      @(negedge core_clk) {sfr_wr, sfr_addr, sfr_wdata} = {1'h1, a, d};
      @(negedge core_clk) {sfr_wr, sfr_addr, sfr_wdata} = {1'h0, ~a, ~d};
   endtask
   task key;
      wr(8'hA6, 8'h1E);
      wr(8'h10, 8'h55);
      wr(8'hA6, 8'hE1);
   endtask
endmodule

// *** bench/hardware_watchdog_bench.sv ***
// Self-checking bench for the hardware watchdog
`timescale 1ns/1ps
module hardware_watchdog_bench;
   // Shortened machine cycle keeps a full timeout near 66k clocks
   localparam logic [3:0] TICK_DIV = 4'h4;
   logic      core_clk = 1'h0, reset_n = 1'h0, osc_running = 1'h1;
   wire       sfr_wr, rst_pin_out, rst_pin_oe, device_reset;
   wire [7:0] sfr_addr, sfr_wdata;
   int        n_errors = 0, cmp_count = 0, n;
   always #4 core_clk = ~core_clk;
   cpu_sfr_writer i_cpu_sfr_writer (
      .core_clk     (core_clk),
      .sfr_wr       (sfr_wr),
      .sfr_addr     (sfr_addr),
      .sfr_wdata    (sfr_wdata)
   );
   hardware_watchdog #(
      .TICK_DIV     (TICK_DIV)
   ) i_hardware_watchdog (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .osc_running  (osc_running),
      .sfr_wr       (sfr_wr),
      .sfr_addr     (sfr_addr),
      .sfr_wdata    (sfr_wdata),
      .rst_pin_out  (rst_pin_out),
      .rst_pin_oe   (rst_pin_oe),
      .device_reset (device_reset)
   );
   task chk(string nm, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task wrap_up;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task wait_pin(input logic lvl, input int lim);
      for (n = 0; n < lim && rst_pin_out !== lvl; n++) @(negedge core_clk);
      if (rst_pin_out !== lvl) begin
         n_errors++;
         wrap_up;
      end
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      @(negedge core_clk) reset_n = 1'h1;
      chk("idle pins", {rst_pin_out, rst_pin_oe, device_reset}, 0);
      i_cpu_sfr_writer.key;
      repeat (3000) @(negedge core_clk);
      i_cpu_sfr_writer.key;
      repeat (2994) @(negedge core_clk);
      i_cpu_sfr_writer.wr(8'hA6, 8'h1E);
      i_cpu_sfr_writer.wr(8'hA6, 8'h55);
      i_cpu_sfr_writer.wr(8'hA6, 8'hE1);
      osc_running = 1'h0;
      repeat (200) @(negedge core_clk);
      osc_running = 1'h1;
      wait_pin(1'h1, 250000);
      // Service edge lies 3200 clocks back, 200 frozen; pin rises 2 edges after the 3FFF tick
      chk("timeout", (n + 2998 >= 16382 * TICK_DIV) && (n + 2998 < 16383 * TICK_DIV), 1);
      chk("pulse drive", {rst_pin_oe, device_reset}, 2'h3);
      wait_pin(1'h0, 200);
      chk("pulse width", n, 98);
      wrap_up;
   end
endmodule
